// ==== rtl/ise_pkg.sv ====
// Constants and carrier types for the two-wire memory access slave
// Operation
// - Byte write: control, address into pointer, one data byte, all acked, then Stop.
// - Register/SRAM write above 0x5F: no acknowledge for address or data, nothing stored.
// - After a single-byte write the pointer holds the next address; array writes wrap within their page and 0xFF stays put.
// - Sequential register/SRAM write: ack, store and advance for every byte, unlimited.
// - Register/SRAM pointer wraps 0x1F to 0x00 and 0x5F to 0x20.
// - Current-address read: ack control byte, send byte at pointer, stop on nack.
// - One pointer is shared by register/SRAM space and array space.
// - Random read: address write loads pointer before repeated Start, then read.
// - Sequential read: each master ack sends the next byte; nack then Stop ends.
// - Protection register at array address 0xFF, field in bits 3-2, rest zero.
// - Protection field: 00 none, 01 60h-7Fh, 10 40h-7Fh, 11 whole array.
// - Several protection bytes: only the last commits, started by Stop.
// - Stop after array write starts write cycle; array control bytes unacked meanwhile.
// - Register/SRAM access stays fully available during an array write cycle.
// - Array write to undefined address: no ack, no store, no write cycle.
// - Page write buffers up to eight bytes and programs them after Stop.
// - Page write advances only low three pointer bits; excess bytes overwrite buffered ones.
// - Control byte 1101111x selects register/SRAM, 1010111x selects the array.
// - Registers occupy 0x00-0x1F, SRAM 0x20-0x5F.
// - Array sequential read wraps pointer 0x7F to 0x00 on master ack.
package ise_pkg;

  localparam logic [6:0] CTRL_RAM       = 7'h6F;
  localparam logic [6:0] CTRL_EE        = 7'h57;
  localparam logic [7:0] RAM_REG_LAST   = 8'h1F;
  localparam logic [7:0] RAM_SRAM_FIRST = 8'h20;
  localparam logic [7:0] RAM_LAST       = 8'h5F;
  localparam logic [7:0] EE_LAST        = 8'h7F;
  localparam logic [7:0] EE_PROT_ADDR   = 8'hFF;
  localparam logic [7:0] PROT_Q_BASE    = 8'h60;
  localparam logic [7:0] PROT_H_BASE    = 8'h40;
  localparam int         BP_LSB         = 2;
  localparam int         RAM_WORDS      = 96;
  localparam int         EE_WORDS       = 128;
  localparam int         PAGE_BYTES     = 8;
  localparam logic [3:0] BIT_ACK        = 4'h8;
  localparam logic [3:0] BIT_ACK_END    = 4'h9;

  localparam int EE_WRITE_TIME_US = 5000;
  localparam int CLK_PERIOD_NS    = 50;
  localparam int EE_WRITE_CYCLES  = (EE_WRITE_TIME_US * 1000) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CTRL,
    ST_ADDR,
    ST_WDATA,
    ST_RDATA,
    ST_IGNORE
  } ise_state_t;

  // Events from the bit engine, one-cycle pulses except rx and mack
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       byte_done;
    logic       mack_done;
    logic       mack;
    logic [7:0] rx;
  } ise_evt_t;

  // Controls to the bit engine
  typedef struct packed {
    logic       ack;
    logic       tx_mode;
    logic [7:0] tx_byte;
  } ise_ctl_t;

endpackage : ise_pkg

// ==== rtl/ise_link.sv ====
// Bit engine: pin synchronisers, Start/Stop detection, byte shifting, SDA drive
`timescale 1ns/10ps
module ise_link (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  input  wire ise_pkg::ise_ctl_t ctl,
  output ise_pkg::ise_evt_t      evt,
  output logic                   sda_oe
);

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       active_r;
  logic       tx_r;
  logic       ack_pend_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  ise_pkg::ise_evt_t evt_r;
  logic       sda_oe_r;

  wire scl_s   = scl_sync_r[1];
  wire sda_s   = sda_sync_r[1];
  wire start_w = scl_s & scl_d_r & sda_d_r & ~sda_s;
  wire stop_w  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  wire rise_w  = scl_s & ~scl_d_r;
  wire fall_w  = ~scl_s & scl_d_r;

  assign evt    = evt_r;
  assign sda_oe = sda_oe_r;

  // Pins come from the master's clock, two stages before use
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end
    else
    begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r    <= scl_s;
      sda_d_r    <= sda_s;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active_r   <= 1'b0;
      tx_r       <= 1'b0;
      ack_pend_r <= 1'b0;
      bit_cnt_r  <= 4'h0;
      sh_r       <= 8'h00;
      evt_r      <= '0;
      sda_oe_r   <= 1'b0;
    end
    else
    begin
      evt_r.start     <= start_w;
      evt_r.stop      <= stop_w;
      evt_r.byte_done <= 1'b0;
      evt_r.mack_done <= 1'b0;
      if (start_w)
      begin
        active_r   <= 1'b1;
        tx_r       <= 1'b0;
        ack_pend_r <= 1'b0;
        bit_cnt_r  <= 4'h0;
        sda_oe_r   <= 1'b0;
      end
      else if (stop_w)
      begin
        active_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end
      else if (active_r)
      begin
        if (ctl.ack)
          ack_pend_r <= 1'b1;
        if (rise_w && bit_cnt_r < ise_pkg::BIT_ACK)
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (!tx_r)
          begin
            sh_r <= {sh_r[6:0], sda_s};
            if (bit_cnt_r == 4'h7)
            begin
              evt_r.byte_done <= 1'b1;
              evt_r.rx        <= {sh_r[6:0], sda_s};
            end
          end
        end
        else if (rise_w)
        begin
          bit_cnt_r <= ise_pkg::BIT_ACK_END;
          if (tx_r)
          begin
            evt_r.mack_done <= 1'b1;
            evt_r.mack      <= ~sda_s;
          end
        end
        if (fall_w && bit_cnt_r == ise_pkg::BIT_ACK)
        begin
          // Master owns the line in its own ack slot
          sda_oe_r   <= ~tx_r & ack_pend_r;
          ack_pend_r <= 1'b0;
        end
        else if (fall_w && bit_cnt_r == ise_pkg::BIT_ACK_END)
        begin
          bit_cnt_r <= 4'h0;
          tx_r      <= ctl.tx_mode;
          sh_r      <= ctl.tx_byte;
          sda_oe_r  <= ctl.tx_mode & ~ctl.tx_byte[7];
        end
        else if (fall_w && tx_r && bit_cnt_r != 4'h0)
          sda_oe_r <= ~sh_r[3'(4'h7 - bit_cnt_r)];
      end
    end
  end

endmodule : ise_link

// ==== rtl/ise_mem_slave.sv ====
// Command layer of the two-wire slave: register/SRAM and array access, protection, write cycle
`timescale 1ns/10ps
module ise_mem_slave #(
  parameter int WRITE_CYCLES = ise_pkg::EE_WRITE_CYCLES
) (
  input  wire logic  clk,
  input  wire logic  nrst,
  input  wire logic  scl_in,
  input  wire logic  sda_in,
  output logic       sda_out,
  output logic       sda_oe,
  output logic       ee_busy,
  output logic [1:0] write_protect_level
);

  ise_pkg::ise_evt_t   evt;
  ise_pkg::ise_ctl_t   ctl_r;
  ise_pkg::ise_state_t st_r;
  logic                link_oe;
  logic                space_ee_r;
  logic [7:0]          ptr_r;
  logic [7:0]          ram_mem  [0:ise_pkg::RAM_WORDS-1];
  logic [7:0]          ee_mem   [0:ise_pkg::EE_WORDS-1];
  logic [7:0]          page_buf [0:ise_pkg::PAGE_BYTES-1];
  logic [7:0]          page_vld_r;
  logic [3:0]          page_base_r;
  logic                ee_pend_r;
  logic                prot_pend_r;
  logic [1:0]          prot_val_r;
  logic [1:0]          bp_r;
  logic                busy_r;
  logic [31:0]         busy_cnt_r;
  logic                sda_out_r;

  ise_link u_link (
    .clk    (clk),
    .nrst   (nrst),
    .scl_in (scl_in),
    .sda_in (sda_in),
    .ctl    (ctl_r),
    .evt    (evt),
    .sda_oe (link_oe)
  );

  assign sda_oe              = link_oe;
  assign sda_out             = sda_out_r;
  assign ee_busy             = busy_r;
  assign write_protect_level = bp_r;

  function automatic logic [7:0] ptr_inc(input logic ee, input logic [7:0] p);
    if (ee)
      return (p == ise_pkg::EE_LAST) ? 8'h00 : p + 8'h01;
    if (p == ise_pkg::RAM_REG_LAST)
      return 8'h00;
    if (p == ise_pkg::RAM_LAST)
      return ise_pkg::RAM_SRAM_FIRST;
    return p + 8'h01;
  endfunction : ptr_inc

  function automatic logic is_prot(input logic [1:0] bp, input logic [7:0] a);
    case (bp)
      2'h1:    return a >= ise_pkg::PROT_Q_BASE;
      2'h2:    return a >= ise_pkg::PROT_H_BASE;
      2'h3:    return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : is_prot

  function automatic logic [7:0] rd_byte(input logic ee, input logic [7:0] p);
    if (ee && p == ise_pkg::EE_PROT_ADDR)
      return 8'(bp_r) << ise_pkg::BP_LSB;
    if (ee)
      return (p <= ise_pkg::EE_LAST) ? ee_mem[p[6:0]] : 8'h00;
    return (p <= ise_pkg::RAM_LAST) ? ram_mem[7'(p)] : 8'h00;
  endfunction : rd_byte

  wire       ctrl_ram  = evt.rx[7:1] == ise_pkg::CTRL_RAM;
  wire       ctrl_ee   = evt.rx[7:1] == ise_pkg::CTRL_EE;
  wire       ctrl_ok   = ctrl_ram | (ctrl_ee & ~busy_r);
  wire       addr_ok   = space_ee_r ? (evt.rx <= ise_pkg::EE_LAST || evt.rx == ise_pkg::EE_PROT_ADDR)
                                    : (evt.rx <= ise_pkg::RAM_LAST);
  wire [7:0] ptr_nxt   = ptr_inc(space_ee_r, ptr_r);
  wire [7:0] page_ptr  = {ptr_r[7:3], ptr_r[2:0] + 3'h1};
  wire       wr_byte   = st_r == ise_pkg::ST_WDATA && evt.byte_done;
  wire       ram_we    = wr_byte && !space_ee_r;
  wire       is_prot_a = ptr_r == ise_pkg::EE_PROT_ADDR;
  wire       ee_buf_we = wr_byte && space_ee_r && !is_prot_a;
  wire       prot_we   = wr_byte && space_ee_r && is_prot_a;
  wire       commit    = evt.stop && (ee_pend_r || prot_pend_r);
  wire       busy_end  = busy_cnt_r == 32'(WRITE_CYCLES - 1);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r       <= ise_pkg::ST_IDLE;
      ctl_r      <= '0;
      space_ee_r <= 1'b0;
      ptr_r      <= 8'h00;
      sda_out_r  <= 1'b0;
    end
    else
    begin
      ctl_r.ack <= 1'b0;
      if (evt.start)
      begin
        st_r          <= ise_pkg::ST_CTRL;
        ctl_r.tx_mode <= 1'b0;
      end
      else if (evt.stop)
      begin
        st_r          <= ise_pkg::ST_IDLE;
        ctl_r.tx_mode <= 1'b0;
      end
      else
      begin
        case (st_r)
          ise_pkg::ST_CTRL:
            if (evt.byte_done && ctrl_ok)
            begin
              ctl_r.ack  <= 1'b1;
              space_ee_r <= ctrl_ee;
              if (evt.rx[0])
              begin
                st_r          <= ise_pkg::ST_RDATA;
                ctl_r.tx_mode <= 1'b1;
                ctl_r.tx_byte <= rd_byte(ctrl_ee, ptr_r);
              end
              else
                st_r <= ise_pkg::ST_ADDR;
            end
            else if (evt.byte_done)
              st_r <= ise_pkg::ST_IGNORE;
          ise_pkg::ST_ADDR:
            if (evt.byte_done && addr_ok)
            begin
              ctl_r.ack <= 1'b1;
              ptr_r     <= evt.rx;
              st_r      <= ise_pkg::ST_WDATA;
            end
            else if (evt.byte_done)
              st_r <= ise_pkg::ST_IGNORE;
          ise_pkg::ST_WDATA:
            if (evt.byte_done)
            begin
              ctl_r.ack <= 1'b1;
              if (!space_ee_r)
                ptr_r <= ptr_nxt;
              else if (!is_prot_a)
                ptr_r <= page_ptr;
            end
          ise_pkg::ST_RDATA:
            if (evt.mack_done)
            begin
              ptr_r <= ptr_nxt;
              if (evt.mack)
                ctl_r.tx_byte <= rd_byte(space_ee_r, ptr_nxt);
              else
              begin
                ctl_r.tx_mode <= 1'b0;
                st_r          <= ise_pkg::ST_IDLE;
              end
            end
          default: ;
        endcase
      end
    end
  end

  // Pending array work and write cycle timer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      page_vld_r  <= 8'h00;
      page_base_r <= 4'h0;
      ee_pend_r   <= 1'b0;
      prot_pend_r <= 1'b0;
      prot_val_r  <= 2'h0;
      bp_r        <= 2'h0;
      busy_r      <= 1'b0;
      busy_cnt_r  <= 32'h0000_0000;
    end
    else
    begin
      if (ee_buf_we)
      begin
        page_vld_r[ptr_r[2:0]] <= 1'b1;
        page_base_r            <= ptr_r[6:3];
        ee_pend_r              <= 1'b1;
      end
      // last byte wins, only field kept
      if (prot_we)
      begin
        prot_val_r  <= evt.rx[ise_pkg::BP_LSB +: 2];
        prot_pend_r <= 1'b1;
      end
      if (commit)
      begin
        ee_pend_r   <= 1'b0;
        prot_pend_r <= 1'b0;
        page_vld_r  <= 8'h00;
        busy_r      <= 1'b1;
        busy_cnt_r  <= 32'h0000_0000;
        if (prot_pend_r)
          bp_r <= prot_val_r;
      end
      else if (busy_r)
      begin
        busy_cnt_r <= busy_cnt_r + 32'h0000_0001;
        if (busy_end)
          busy_r <= 1'b0;
      end
    end
  end

  // Memories are not reset, like real SRAM and array cells
  always_ff @(posedge clk)
  begin
    if (ram_we)
      ram_mem[7'(ptr_r)] <= evt.rx;
    if (ee_buf_we)
      page_buf[ptr_r[2:0]] <= evt.rx;
    if (commit && ee_pend_r)
    begin
      for (int i = 0; i < ise_pkg::PAGE_BYTES; i++)
      begin
        // protected bytes left as they are
        if (page_vld_r[i] && !is_prot(bp_r, {1'b0, page_base_r, 3'(i)}))
          ee_mem[{page_base_r, 3'(i)}] <= page_buf[i];
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  property p_busy_refuse;
    (st_r == ise_pkg::ST_CTRL && evt.byte_done && ctrl_ee && busy_r && !evt.start && !evt.stop)
      |=> !ctl_r.ack && st_r == ise_pkg::ST_IGNORE;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("Array control acked while busy");

  property p_ram_addr_nack;
    (st_r == ise_pkg::ST_ADDR && evt.byte_done && !space_ee_r && evt.rx > ise_pkg::RAM_LAST)
      |=> !ctl_r.ack && st_r == ise_pkg::ST_IGNORE && ptr_r == $past(ptr_r);
  endproperty
  a_ram_addr_nack: assert property (p_ram_addr_nack) else $error("Out of range address acked");

  property p_wrap_reg;
    (ram_we && ptr_r == ise_pkg::RAM_REG_LAST) |=> ptr_r == 8'h00;
  endproperty
  a_wrap_reg: assert property (p_wrap_reg) else $error("Register block did not wrap");

  property p_wrap_sram;
    (ram_we && ptr_r == ise_pkg::RAM_LAST) |=> ptr_r == ise_pkg::RAM_SRAM_FIRST;
  endproperty
  a_wrap_sram: assert property (p_wrap_sram) else $error("SRAM block did not wrap");

  property p_page_roll;
    ee_buf_we |=> ptr_r[7:3] == $past(ptr_r[7:3]) && ptr_r[2:0] == $past(ptr_r[2:0]) + 3'h1;
  endproperty
  a_page_roll: assert property (p_page_roll) else $error("Page pointer left its page");

  property p_commit_busy;
    (evt.stop && ee_pend_r) |=> busy_r && !ee_pend_r ##1 busy_r;
  endproperty
  a_commit_busy: assert property (p_commit_busy) else $error("Stop did not start write cycle");

  property p_busy_hold;
    $rose(busy_r) |-> busy_r [*8];
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Write cycle ended too early");

  property p_rd_wrap;
    (st_r == ise_pkg::ST_RDATA && evt.mack_done && space_ee_r && ptr_r == ise_pkg::EE_LAST && !evt.start)
      |=> ptr_r == 8'h00;
  endproperty
  a_rd_wrap: assert property (p_rd_wrap) else $error("Array read did not wrap");

  property p_prot_commit;
    (evt.stop && prot_pend_r) |=> bp_r == $past(prot_val_r) && !prot_pend_r;
  endproperty
  a_prot_commit: assert property (p_prot_commit) else $error("Protection field not committed");

  c_page_commit: cover property (evt.stop && ee_pend_r && page_vld_r == 8'hFF);
  c_seq_read: cover property (st_r == ise_pkg::ST_RDATA && evt.mack_done && evt.mack);
  c_busy_refuse: cover property (st_r == ise_pkg::ST_CTRL && evt.byte_done && ctrl_ee && busy_r);
  c_ram_during_busy: cover property (ram_we && busy_r);

endmodule : ise_mem_slave

// ==== testbench/ise_bus_master.sv ====
// Two-wire bus master model timed from its own link clock
`timescale 1ns/10ps
module ise_bus_master #(
  parameter int HALF   = 30,
  parameter int SETTLE = 8
) (
  input  wire logic lclk,
  input  wire logic sda,
  output logic      scl_lo,
  output logic      sda_lo
);
  // Both lines released: the pull-ups hold the idle bus high
  initial
  begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge lclk);
  endtask : tick

  // SDA moves only while SCL is low, well clear of the fall
  task automatic bit_io(input logic drive_low, output logic seen);
    sda_lo <= drive_low;
    tick(HALF);
    scl_lo <= 1'b0;
    tick(HALF);
    seen = sda;
    scl_lo <= 1'b1;
    tick(SETTLE);
  endtask : bit_io

  // Also a repeated start; waits out the device's ack release
  task automatic start_cond();
    sda_lo <= 1'b0;
    tick(HALF);
    scl_lo <= 1'b0;
    tick(HALF);
    sda_lo <= 1'b1;
    tick(HALF);
    scl_lo <= 1'b1;
    tick(SETTLE);
  endtask : start_cond

  task automatic stop_cond();
    sda_lo <= 1'b1;
    tick(HALF);
    scl_lo <= 1'b0;
    tick(HALF);
    sda_lo <= 1'b0;
    tick(HALF);
  endtask : stop_cond

  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(~b[i], s);
    bit_io(1'b0, s);
    ack = ~s;
  endtask : put_byte

  task automatic get_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++)
    begin
      bit_io(1'b0, s);
      b = {b[6:0], s};
    end
    bit_io(~last, s);
  endtask : get_byte

  task automatic poll(input logic [7:0] ctrl, input int limit, output logic ok);
    logic a;
    ok = 1'b0;
    for (int i = 0; i < limit && !ok; i++)
    begin
      start_cond();
      put_byte(ctrl, a);
      ok = a;
    end
    stop_cond();
  endtask : poll
endmodule : ise_bus_master

// ==== testbench/i2c_sram_eeprom_access_bench.sv ====
// Self-checking bench for the two-wire memory slave
`timescale 1ns/10ps
module i2c_sram_eeprom_access_bench;
  localparam int         WCYC = 1000;
  localparam logic [6:0] RAM  = ise_pkg::CTRL_RAM;
  localparam logic [6:0] EE   = ise_pkg::CTRL_EE;
  logic       clk  = 1'b0;
  logic       lclk = 1'b0;
  logic       nrst = 1'b0;
  logic       m_scl_lo;
  logic       m_sda_lo;
  logic       d_sda_out;
  logic       d_sda_oe;
  logic       d_busy;
  logic [1:0] d_level;
  logic       ok;
  int         bad_count = 0;
  int         tests_run = 0;
  logic [7:0] wd [16];
  logic [7:0] rd [16];
  logic [7:0] probe [4] = '{8'h00, 8'h40, 8'h60, 8'h7F};
  // Open-drain wires with pull-ups
  wire        scl_w = ~m_scl_lo;
  wire        sda_w = (d_sda_oe ? d_sda_out : 1'b1) & ~m_sda_lo;

  always #25 clk = ~clk;
  initial
  begin
    #3.3;
    forever #7.5 lclk = ~lclk;
  end

  ise_mem_slave #(.WRITE_CYCLES(WCYC)) i_dut (
    .clk(clk), .nrst(nrst), .scl_in(scl_w), .sda_in(sda_w), .sda_out(d_sda_out),
    .sda_oe(d_sda_oe), .ee_busy(d_busy), .write_protect_level(d_level));
  ise_bus_master i_master (.lclk(lclk), .sda(sda_w), .scl_lo(m_scl_lo), .sda_lo(m_sda_lo));

  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s: got %b want %b", $time, what, got, exp);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : chk_byte

  task automatic results();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic fill(input logic [7:0] d0, input int n);
    for (int i = 0; i < n; i++)
      wd[i] = d0 + 8'(i);
  endtask : fill

  task automatic try_ctrl(input logic [7:0] c, input logic exp);
    logic a;
    i_master.start_cond();
    i_master.put_byte(c, a);
    chk_bit(a, exp, "ctrl ack");
    i_master.stop_cond();
  endtask : try_ctrl

  task automatic wr(input logic [6:0] dev, input logic [7:0] addr, input int n, input logic exp);
    logic a;
    i_master.start_cond();
    i_master.put_byte({dev, 1'b0}, a);
    chk_bit(a, 1'b1, "ctrl ack");
    i_master.put_byte(addr, a);
    chk_bit(a, exp, "addr ack");
    for (int i = 0; i < n; i++)
    begin
      i_master.put_byte(wd[i], a);
      chk_bit(a, exp, "data ack");
    end
    i_master.stop_cond();
  endtask : wr

  task automatic rd_seq(input logic [6:0] dev, input logic set, input logic [7:0] addr, input int n);
    logic a;
    i_master.start_cond();
    if (set)
    begin
      i_master.put_byte({dev, 1'b0}, a);
      chk_bit(a, 1'b1, "ctrl ack");
      i_master.put_byte(addr, a);
      chk_bit(a, 1'b1, "addr ack");
      i_master.start_cond();
    end
    i_master.put_byte({dev, 1'b1}, a);
    chk_bit(a, 1'b1, "read ctrl ack");
    for (int i = 0; i < n; i++)
      i_master.get_byte(i == n - 1, rd[i]);
    i_master.stop_cond();
  endtask : rd_seq

  task automatic wait_ready();
    i_master.poll({EE, 1'b0}, 20, ok);
    chk_bit(ok, 1'b1, "poll");
  endtask : wait_ready

  initial
  begin
    repeat (90000) @(posedge clk);
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    chk_byte({6'h00, d_level}, 8'h00, "level reset");
    chk_bit(d_busy, 1'b0, "busy reset");
    fill(8'hA5, 4);
    wr(RAM, 8'h25, 4, 1'b1);
    fill(8'h5A, 1);
    wr(RAM, 8'h24, 1, 1'b1);
    rd_seq(RAM, 1'b0, 8'h00, 1);
    chk_byte(rd[0], 8'hA5, "next after write");
    rd_seq(RAM, 1'b1, 8'h24, 3);
    chk_byte(rd[0], 8'h5A, "random");
    chk_byte(rd[1], 8'hA5, "seq 1");
    chk_byte(rd[2], 8'hA6, "seq 2");
    rd_seq(RAM, 1'b0, 8'h00, 1);
    chk_byte(rd[0], 8'hA7, "current");
    fill(8'h10, 3);
    wr(RAM, 8'h5E, 3, 1'b1);
    fill(8'h30, 2);
    wr(RAM, 8'h1F, 2, 1'b1);
    rd_seq(RAM, 1'b1, 8'h5F, 2);
    chk_byte(rd[1], 8'h12, "sram wrap");
    rd_seq(RAM, 1'b1, 8'h1F, 2);
    chk_byte(rd[1], 8'h31, "reg wrap");
    wr(RAM, 8'h60, 1, 1'b0);
    try_ctrl(8'hA0, 1'b0);
    fill(8'h40, 10);
    wr(EE, 8'h08, 10, 1'b1);
    chk_bit(d_busy, 1'b1, "busy after stop");
    try_ctrl({EE, 1'b0}, 1'b0);
    rd_seq(RAM, 1'b1, 8'h24, 1);
    chk_byte(rd[0], 8'h5A, "ram while busy");
    wait_ready();
    rd_seq(EE, 1'b1, 8'h08, 8);
    for (int i = 0; i < 8; i++)
      chk_byte(rd[i], (i < 2) ? 8'(8'h48 + i) : 8'(8'h40 + i), "page");
    wr(RAM, 8'h09, 0, 1'b1);
    rd_seq(EE, 1'b0, 8'h00, 1);
    chk_byte(rd[0], 8'h49, "shared pointer");
    wr(EE, 8'h80, 1, 1'b0);
    chk_bit(d_busy, 1'b0, "no cycle");
    try_ctrl({EE, 1'b0}, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      fill(8'(8'h90 + i), 1);
      wr(EE, probe[i], 1, 1'b1);
      wait_ready();
    end
    rd_seq(EE, 1'b1, 8'h7F, 2);
    chk_byte(rd[0], 8'h93, "unprotected");
    chk_byte(rd[1], 8'h90, "array wrap");
    for (int lv = 1; lv < 4; lv++)
    begin
      wd[0] = 8'hFF;
      wd[1] = {4'hF, 2'(lv), 2'b11};
      wr(EE, ise_pkg::EE_PROT_ADDR, 2, 1'b1);
      wait_ready();
      chk_byte({6'h00, d_level}, 8'(lv), "level");
      rd_seq(EE, 1'b1, ise_pkg::EE_PROT_ADDR, 1);
      chk_byte(rd[0], {4'h0, 2'(lv), 2'b00}, "prot reg");
      fill(8'hEE, 1);
      wr(EE, probe[3-lv], 1, 1'b1);
      wait_ready();
      rd_seq(EE, 1'b1, probe[3-lv], 1);
      chk_byte(rd[0], 8'(8'h93 - lv), "protected");
    end
    results();
  end
endmodule : i2c_sram_eeprom_access_bench
